// ---- pkg/rem_pkg.sv ----
// Purpose: constants for the receiver error interrupt mask block
// Assumes: 32-bit AXI4-Lite register bus, byte offsets
// Notes: offsets 0x18/0x19 kept as register indices, byte address = 4x
package rem_pkg;
    localparam int unsigned NUM_FLAGS = 8;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h18;
    localparam logic [7:0] IDX_MASK   = 8'h19;
    localparam logic [7:0] IDX_EVENT  = 8'h1C; // sticky event status
    localparam logic [7:0] IDX_EVMASK = 8'h1D; // event interrupt mask
    localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [9:0] ADDR_MASK   = {IDX_MASK, 2'b00};
    localparam logic [9:0] ADDR_EVENT  = {IDX_EVENT, 2'b00};
    localparam logic [9:0] ADDR_EVMASK = {IDX_EVMASK, 2'b00};
    // flag bit positions
    localparam int unsigned BIT_LOCK     = 0;
    localparam int unsigned BIT_BIPHASE  = 1;
    localparam int unsigned BIT_INPUT_STREAM_ABSENT = 2;
    localparam int unsigned BIT_CHKSUM   = 3;
    localparam int unsigned BIT_PREAMBLE = 4;
    localparam int unsigned BIT_NONAUDIO = 5;
    localparam int unsigned BIT_EMPH     = 6;
    localparam int unsigned BIT_VALIDITY = 7;
    // flags that hold until read (others follow a level, alert on change)
    localparam logic [7:0] STICKY_SET  = 8'h0A;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [7:0] EVMASK_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- logic/rem_flag.sv ----
// Purpose: one receiver status flag with its pending-interrupt bit
// Assumes: inputs are synchronised to aclk
// Notes: sticky flags hold until read; level flags alert on change
`timescale 1ns/1ps
module rem_flag #(
    parameter bit STICKY = 1'b0
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic src,
    input  wire logic rd_clr,
    output logic      flag,
    output logic      pend
);
    logic prev_reg;

    // previous source level for change detect
    always_ff @(posedge aclk) begin
        if (!aresetn) prev_reg <= 1'b0;
        else          prev_reg <= src;
    end

    // flag value; sticky set wins over read clear
    always_ff @(posedge aclk) begin
        if (!aresetn)       flag <= 1'b0;
        else if (!STICKY)   flag <= src;
        else if (src)       flag <= 1'b1;
        else if (rd_clr)    flag <= 1'b0;
    end

    // pending alert: set while a sticky source is high or on a level change; read clears, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn)                      pend <= 1'b0;
        else if (STICKY ? src : src != prev_reg) pend <= 1'b1;
        else if (rd_clr)                   pend <= 1'b0;
    end
endmodule // rem_flag

// ---- logic/rem_top.sv ----
// Purpose: receiver error status, mask and interrupt over AXI4-Lite
// Assumes: raw flag inputs are asynchronous; synchronised here
// Notes: irq is registered; one write and one read at a time
// Behaviour
// - mask bit 5 lets the non-audio detection flag raise an interrupt.
// - mask bit 4 lets the non-audio preamble type flag interrupt.
// - mask bit 3 lets the channel status checksum error interrupt.
// - mask bit 2 lets the input stream absent flag interrupt.
// - mask bit 1 lets the biphase or parity error interrupt.
// - a biphase or parity error sets its flag, held until status read.
// - stream absent follows the input; after a read no new interrupt
//     until it changes.
// - emphasis follows the input; after a read no new interrupt until
//     it changes.
`timescale 1ns/1ps
module rem_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  rx_flags_in,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);
    localparam int unsigned N = rem_pkg::NUM_FLAGS;

    logic [N-1:0]  sync1_reg;
    logic [N-1:0]  sync2_reg;
    logic [N-1:0]  flag_w;
    logic [N-1:0]  pend_w;
    logic [N-1:0]  mask_reg;
    logic [N-1:0]  event_reg;
    logic [N-1:0]  evmask_reg;
    logic [N-1:0]  pend_prev_reg;
    logic          stat_rd;
    logic          aw_got_reg;
    logic          w_got_reg;
    logic [11:0]   awaddr_reg;
    logic [31:0]   wdata_reg;
    logic [3:0]    wstrb_reg;
    logic          wr_fire;
    logic [N-1:0]  ev_clr;
    logic [N-1:0]  ev_set;

    // two-stage synchroniser for the raw flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= rx_flags_in;
            sync2_reg <= sync1_reg;
        end
    end

    // status read clears sticky flags and pending alerts
    assign stat_rd = s_axi_arvalid && s_axi_arready
                     && s_axi_araddr[9:0] == rem_pkg::ADDR_STATUS;

    // one flag cell per status bit
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flag
            rem_flag #(
                .STICKY (rem_pkg::STICKY_SET[g])
            ) u_flag (
                .aclk    (aclk),
                .aresetn (aresetn),
                .src     (sync2_reg[g]),
                .rd_clr  (stat_rd),
                .flag    (flag_w[g]),
                .pend    (pend_w[g])
            );
        end
    endgenerate

    // write address and data, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_reg <= 1'b0;
            end
        end
    end

    // write readies, registered; low from a handshake until the response
    // has gone, so only one write is ever held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awready <= 1'b0;
            else if (!aw_got_reg && !s_axi_bvalid)
                s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wready <= 1'b0;
            else if (!w_got_reg && !s_axi_bvalid)
                s_axi_wready <= 1'b1;
        end
    end

    assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rem_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            unique case (awaddr_reg[9:0])
                rem_pkg::ADDR_MASK, rem_pkg::ADDR_EVENT,
                rem_pkg::ADDR_EVMASK,
                rem_pkg::ADDR_STATUS: s_axi_bresp <= rem_pkg::RESP_OKAY;
                default:              s_axi_bresp <= rem_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // mask registers, low byte lane only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg   <= rem_pkg::MASK_RESET;
            evmask_reg <= rem_pkg::EVMASK_RESET;
        end else if (wr_fire && wstrb_reg[0]) begin
            if (awaddr_reg[9:0] == rem_pkg::ADDR_MASK)
                mask_reg <= wdata_reg[N-1:0];
            if (awaddr_reg[9:0] == rem_pkg::ADDR_EVMASK)
                evmask_reg <= wdata_reg[N-1:0];
        end
    end

    // gated alert rising edge sets a sticky event bit
    always_ff @(posedge aclk) begin
        if (!aresetn) pend_prev_reg <= '0;
        else          pend_prev_reg <= pend_w & mask_reg;
    end

    // per-bit enable of each flag through the mask
    assign ev_set = pend_w & mask_reg
                    & ~pend_prev_reg;
    assign ev_clr = (wr_fire && wstrb_reg[0]
                     && awaddr_reg[9:0] == rem_pkg::ADDR_EVENT)
                    ? wdata_reg[N-1:0] : '0;

    // sticky events, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) event_reg <= '0;
        else          event_reg <= (event_reg & ~ev_clr) | ev_set;
    end

    // interrupt level: any unmasked pending alert or event
    always_ff @(posedge aclk) begin
        if (!aresetn) irq <= 1'b0;
        else irq <= |((pend_w & mask_reg)
                      | (event_reg & evmask_reg));
    end

    // read channel
    // read ready, registered; low from a handshake until rvalid has gone
    always_ff @(posedge aclk) begin
        if (!aresetn)
            s_axi_arready <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready)
            s_axi_arready <= 1'b0;
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= rem_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rem_pkg::RESP_OKAY;
            unique case (s_axi_araddr[9:0])
                rem_pkg::ADDR_STATUS: s_axi_rdata <= {24'h000000, flag_w};
                rem_pkg::ADDR_MASK:   s_axi_rdata <= {24'h000000, mask_reg};
                rem_pkg::ADDR_EVENT:  s_axi_rdata <= {24'h000000, event_reg};
                rem_pkg::ADDR_EVMASK: s_axi_rdata <= {24'h000000, evmask_reg};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= rem_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // rem_top

// ---- sim/rem_chk.sv ----
// Purpose: port assertions for rem_top
// Assumes: write address and data offered together
// Notes: keeps a shadow of the mask register
`timescale 1ns/1ps
module rem_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  rx_flags_in,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    logic [7:0] msk_reg;
    logic [9:0] ra;
    logic       ar;
    logic       st;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // read taken, its address, status read
    assign ar = s_axi_arvalid && s_axi_arready;
    assign ra = s_axi_araddr[9:0];
    assign st = ar && ra == rem_pkg::ADDR_STATUS;
    // mask shadow from bus writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msk_reg <= rem_pkg::MASK_RESET;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
                     && s_axi_awaddr[9:0] == rem_pkg::ADDR_MASK) begin
            msk_reg <= s_axi_wdata[7:0];
        end
    end
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped");
    property p_rh; s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rh: assert property (p_rh) else $error("rvalid dropped");
    property p_ra; ar |=> s_axi_rvalid;
    endproperty
    a_ra: assert property (p_ra) else $error("no read answer");
    property p_un; ar && ra == 10'h3FC
        |=> s_axi_rresp == rem_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_un: assert property (p_un) else $error("unmapped read");
    property p_ms; ar && ra == rem_pkg::ADDR_MASK
        |=> s_axi_rdata == {24'h0, msk_reg};
    endproperty
    a_ms: assert property (p_ms) else $error("mask readback");
    property p_io; (msk_reg == 8'h00) [*6] |-> !irq;
    endproperty
    a_io: assert property (p_io) else $error("irq unmasked");
    property p_st; rx_flags_in[1] [*5] ##0 st |=> s_axi_rdata[1];
    endproperty
    a_st: assert property (p_st) else $error("sticky lost");
    property p_lv; $stable(rx_flags_in) [*5] ##0 st
        |=> s_axi_rdata[2] == $past(rx_flags_in[2])
        && s_axi_rdata[6] == $past(rx_flags_in[6]);
    endproperty
    a_lv: assert property (p_lv) else $error("level flag");
endmodule // rem_chk

bind rem_top rem_chk i_chk (.*);

// ---- sim/receiver_error_irq_mask_tb.sv ----
// Purpose: self-checking bench for rem_top
// Assumes: AXI4-Lite master raising ready late
// Notes: raw flags driven straight onto the inputs
`timescale 1ns/1ps
module receiver_error_irq_mask_tb;
    logic        aclk, aresetn, irq, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  rx_flags_in;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    int          fails = 0;
    int          n_compared = 0;
    localparam logic [11:0] AM = {2'b00, rem_pkg::ADDR_MASK};
    localparam logic [11:0] AS = {2'b00, rem_pkg::ADDR_STATUS};
    localparam logic [11:0] AE = {2'b00, rem_pkg::ADDR_EVENT};
    localparam logic [11:0] AV = {2'b00, rem_pkg::ADDR_EVMASK};
    rem_top i_dut (.*);
    // clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // verdict and end of run
    task automatic stop_test();
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: %h vs %h", $time, s, e);
        end
    endtask
    // one access; late ready so the answer must hold
    task automatic bus(input bit w, input logic [11:0] a, logic [31:0] d);
        bit hw, ha, hr;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            hw = s_axi_wvalid && s_axi_wready;
            ha = s_axi_awvalid && s_axi_awready
                 || s_axi_arvalid && s_axi_arready;
            hr = w ? s_axi_bvalid && s_axi_bready
                   : s_axi_rvalid && s_axi_rready;
            {q, r} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
            @(posedge aclk);
            if (hw) s_axi_wvalid <= 1'b0;
            if (ha) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (n == 3) {s_axi_bready, s_axi_rready} <= {w, !w};
            if (hr) begin
                {s_axi_bready, s_axi_rready} <= 2'b00;
                return;
            end
        end
        fails++;
        stop_test();
    endtask
    // reset value, read-back, unmapped place
    task automatic t_regs();
        @(negedge aclk);
        chk(32'(irq), 32'h0);
        bus(0, AM, 32'h0);
        chk(q, 32'(rem_pkg::MASK_RESET));
        bus(1, AM, 32'hFFFF_FF5A);
        chk(32'(r), 32'(rem_pkg::RESP_OKAY));
        bus(0, AM, 32'h0);
        chk(q, 32'h5A);
        bus(0, 12'h3FC, 32'h0);
        chk(32'(r), 32'(rem_pkg::RESP_SLVERR));
        bus(1, AM, 32'h0);
    endtask
    // one flag: blocked by clear mask bit, passed by set one
    task automatic t_bit(input logic [7:0] b);
        @(posedge aclk);
        rx_flags_in <= b;
        repeat (4) @(posedge aclk);
        rx_flags_in <= 8'h00;
        repeat (6) @(negedge aclk);
        chk(32'(irq), 32'h0);
        bus(1, AM, {24'h0, b});
        repeat (3) @(negedge aclk);
        chk(32'(irq), 32'h1);
        bus(0, AS, 32'h0);
        chk(q, 32'(rem_pkg::STICKY_SET & b));
        repeat (3) @(negedge aclk);
        chk(32'(irq), 32'h0);
        bus(1, AM, 32'h0);
    endtask
    // level flags stay quiet after a read until they change
    task automatic t_level();
        @(posedge aclk);
        rx_flags_in <= 8'h46;
        repeat (6) @(negedge aclk);
        bus(0, AS, 32'h0);
        chk(q, 32'h46);
        @(posedge aclk);
        rx_flags_in <= 8'h44;
        repeat (6) @(negedge aclk);
        bus(0, AS, 32'h0);
        chk(q, 32'h46);
        bus(1, AM, 32'hFF);
        repeat (3) @(negedge aclk);
        chk(32'(irq), 32'h0);
        @(posedge aclk);
        rx_flags_in <= 8'h40;
        repeat (6) @(negedge aclk);
        chk(32'(irq), 32'h1);
        bus(0, AS, 32'h0);
        chk(q, 32'h40);
    endtask
    // sticky event with its mask, write one to clear, bad write place
    task automatic t_event();
        bus(1, AE, 32'hFF);
        chk(32'(r), 32'(rem_pkg::RESP_OKAY));
        bus(1, AV, 32'hFF);
        bus(0, AV, 32'h0);
        chk(q, 32'hFF);
        @(posedge aclk);
        rx_flags_in <= 8'h60;
        repeat (6) @(negedge aclk);
        bus(0, AS, 32'h0);
        chk(q, 32'h60);
        repeat (3) @(negedge aclk);
        chk(32'(irq), 32'h1);
        bus(0, AE, 32'h0);
        chk(q, 32'h20);
        bus(1, AE, 32'h20);
        repeat (3) @(negedge aclk);
        chk(32'(irq), 32'h0);
        bus(1, 12'h3FC, 32'h0);
        chk(32'(r), 32'(rem_pkg::RESP_SLVERR));
    endtask
    // reset, then the scenarios
    initial begin
        {aresetn, rx_flags_in, s_axi_wstrb} = {1'b0, 8'h00, 4'hF};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
        {s_axi_bready, s_axi_rready} = 2'b00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        for (int i = 0; i < 8; i++) t_bit(8'h01 << i);
        t_level();
        t_event();
        stop_test();
    end
endmodule // receiver_error_irq_mask_tb
